// >>> hdl/sm_params.svh
// Constants of the serial master: timing, encodings and field positions.
// Assumes nothing; included by the serial master design file by its bare name.
`ifndef SM_PARAMS_SVH
`define SM_PARAMS_SVH

// -----------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------
`define SM_CLK_HZ 200000000
`define SM_SCLK_MAX_HZ 25000000
// Least divider: rounded up so the serial clock never passes its ceiling
`define SM_MIN_DIV ((`SM_CLK_HZ + `SM_SCLK_MAX_HZ - 1) / `SM_SCLK_MAX_HZ)
`define SM_DLY_MAX 8'h19

// -----------------------------------------------------------------------
// Encodings and sizes
// -----------------------------------------------------------------------
`define SM_OWNER_MASTER 2'h2
`define SM_TM_TXRX 2'h0
`define SM_TM_TX 2'h1
`define SM_TM_RX 2'h2
`define SM_FS_MIN 4'h3
`define SM_FS_MAX 4'hF
`define SM_DATA_W 16
`define SM_FIFO_DEPTH 8
`define SM_NCS 5
`define SM_CS_IDLE 5'h1F
`define SM_MASK_RST 5'h1F

// -----------------------------------------------------------------------
// Interrupt bit positions
// -----------------------------------------------------------------------
`define SM_IRQ_TXE 0
`define SM_IRQ_TXO 1
`define SM_IRQ_RXU 2
`define SM_IRQ_RXO 3
`define SM_IRQ_RXF 4

`endif

// >>> hdl/sm_pkg.sv
// Types shared by the serial master design.
// Assumes the constants of sm_params.svh for the meaning of the fields.
package sm_pkg;

    typedef enum logic [1:0] {SM_IDLE, SM_PULSE, SM_BIT, SM_END} sm_phase_t;

    typedef struct packed {
        logic frame_format;
        logic frame_protocol_enable;
        logic [1:0] transfer_mode;
        logic clock_polarity;
        logic clock_phase;
        logic [3:0] frame_size;
        logic [4:0] slave_select;
        logic [15:0] divider_value;
        logic [15:0] rx_frame_count;
    } sm_cfg_t;

    typedef struct packed {
        logic busy;
        logic tx_empty;
        logic tx_not_full;
        logic rx_full;
        logic rx_not_empty;
    } sm_status_t;

    typedef struct packed {
        sm_phase_t st;
        sm_cfg_t cfg;
        logic [7:0] dly_set;
        logic [4:0] mask;
        logic [15:0] cnt;
        logic ph;
        logic [3:0] bi;
        logic [15:0] tx_sh;
        logic [15:0] rx_sh;
        logic [3:0] rxb;
        logic [4:0] dly;
        logic pend;
        logic [15:0] rx_left;
        logic sclk;
        logic mosi;
        logic [4:0] cs_n;
        logic oe_n;
        logic tx_overflow_irq;
        logic rx_overflow_irq;
        logic rx_underflow_irq;
        logic [4:0] raw;
        logic [4:0] masked;
        logic irq;
        logic [15:0] rx_data;
        logic rx_dv;
        sm_status_t stat;
        logic [3:0] txl;
        logic [3:0] rxl;
    } sm_regs_t;

endpackage

// >>> hdl/sm_serial_master.sv
// Serial master with SPI and SSP framing, two FIFOs and interrupt status.
// Assumes one 200 MHz clock; all inputs are synchronous to it and the
// configuration ports are held by software like register contents.
//
// Notes on behaviour
// - SSP only when format and protocol enable set
// - Serial clock from divider, never above 25 MHz
// - Pins driven only when ownership equals 2
// - Frame size 4 to 16 bits per entry
// - Transmit-receive: one received frame per sent frame
// - Transmit-only discards incoming serial data
// - Receive-only starts on one write, reads count
// - SPI select held whole transfer, ends empty
// - Five active-low selects chosen by slave select
// - Data port pushes transmit, pops receive; flags
// - Capture delay in clocks, over 25 is zero
// - Enable after configuration; config locked while enabled
// - All four polarity and phase combinations in SPI
// - Capture bit at eye centre plus delay
// - Receive level interrupt while fill exceeds threshold
// - Transmit level interrupt while fill below threshold
// - Overflow and underflow latch until their clear
// - Raw status, mask reset enabled, masked status
// - Interrupt needs unmasked source and enabled controller
`timescale 1ns/1ps
`include "sm_params.svh"

// -----------------------------------------------------------------------
// FIFO
// -----------------------------------------------------------------------
// Depth must be a power of two; pointers wrap by overflow.
module sm_fifo #(
    parameter int W = 16,
    parameter int D = 8,
    parameter int LW = $clog2(D + 1)
) (
    input logic clk_i,
    input logic nrst_i,
    input logic flush_i,
    input logic in_valid_i,
    output logic in_ready_o,
    input logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input logic out_ready_i,
    output logic [W-1:0] out_data_o,
    output logic [LW-1:0] level_o
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [LW-1:0] lvl;
    } sm_fifo_st_t;

    sm_fifo_st_t s_r;
    sm_fifo_st_t s_nxt;
    logic push;
    logic pop;

    assign in_ready_o = s_r.lvl != LW'(D);
    assign out_valid_o = s_r.lvl != '0;
    assign out_data_o = s_r.mem[s_r.rp];
    assign level_o = s_r.lvl;

    always_comb
    begin
        s_nxt = s_r;
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        if (push)
        begin
            s_nxt.mem[s_r.wp] = in_data_i;
            s_nxt.wp = s_r.wp + AW'(1);
        end
        if (pop)
            s_nxt.rp = s_r.rp + AW'(1);
        s_nxt.lvl = s_r.lvl + LW'(push) - LW'(pop);
        if (flush_i)
        begin
            s_nxt.wp = '0;
            s_nxt.rp = '0;
            s_nxt.lvl = '0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
endmodule // sm_fifo

// -----------------------------------------------------------------------
// Serial master
// -----------------------------------------------------------------------
module sm_serial_master (
    input logic CLK_I,
    input logic NRST_I,
    input logic CONTROLLER_ENABLE_I,
    input logic [1:0] IF_OWNER_I,
    input sm_pkg::sm_cfg_t CFG_I,
    input logic [7:0] RX_CAPTURE_DELAY_I,
    input logic RX_CAPTURE_DELAY_WE_I,
    input logic [3:0] TX_THRESHOLD_I,
    input logic [3:0] RX_THRESHOLD_I,
    input logic [4:0] IRQ_MASK_I,
    input logic IRQ_MASK_WE_I,
    input logic TX_WR_I,
    input logic [15:0] TX_DATA_I,
    input logic RX_RD_I,
    input logic TX_OVERFLOW_CLEAR_I,
    input logic RX_OVERFLOW_CLEAR_I,
    input logic RX_UNDERFLOW_CLEAR_I,
    input logic SERIAL_DATA_IN_I,
    output logic SCLK_O,
    output logic MOSI_O,
    output logic [4:0] CHIP_SELECT_N_O,
    output logic PIN_OE_N_O,
    output logic [15:0] RX_DATA_O,
    output logic RX_DATA_VALID_O,
    output sm_pkg::sm_status_t STATUS_O,
    output logic [3:0] TX_FILL_LEVEL_O,
    output logic [3:0] RX_FILL_LEVEL_O,
    output logic [4:0] RAW_IRQ_STATUS_O,
    output logic [4:0] MASKED_IRQ_STATUS_O,
    output logic IRQ_O
);
    sm_pkg::sm_regs_t s_r;
    sm_pkg::sm_regs_t s_nxt;

    logic go;
    logic ssp;
    logic cpha_e;
    logic cpol_e;
    logic [3:0] fs;
    logic [15:0] div_e;
    logic tick;
    logic [4:0] dly_e;
    logic more;
    logic [15:0] rx_mask;
    logic tx_in_ready;
    logic tx_out_valid;
    logic tx_pop;
    logic [15:0] tx_out_data;
    logic [3:0] tx_level;
    logic rx_push;
    logic rx_in_ready;
    logic rx_out_valid;
    logic rx_pop;
    logic [15:0] rx_in_data;
    logic [15:0] rx_out_data;
    logic [3:0] rx_level;
    logic txo_ev;
    logic rxo_ev;
    logic rxu_ev;
    logic [4:0] raw;

    // Disabling flushes both FIFOs, so stale frames never leak out
    sm_fifo #(.W(`SM_DATA_W), .D(`SM_FIFO_DEPTH)) u_tx_fifo (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .flush_i(!CONTROLLER_ENABLE_I),
        .in_valid_i(TX_WR_I),
        .in_ready_o(tx_in_ready),
        .in_data_i(TX_DATA_I),
        .out_valid_o(tx_out_valid),
        .out_ready_i(tx_pop),
        .out_data_o(tx_out_data),
        .level_o(tx_level)
    );

    sm_fifo #(.W(`SM_DATA_W), .D(`SM_FIFO_DEPTH)) u_rx_fifo (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .flush_i(!CONTROLLER_ENABLE_I),
        .in_valid_i(rx_push),
        .in_ready_o(rx_in_ready),
        .in_data_i(rx_in_data),
        .out_valid_o(rx_out_valid),
        .out_ready_i(rx_pop),
        .out_data_o(rx_out_data),
        .level_o(rx_level)
    );

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        go = CONTROLLER_ENABLE_I && IF_OWNER_I == `SM_OWNER_MASTER;
        ssp = s_r.cfg.frame_format && s_r.cfg.frame_protocol_enable;
        cpha_e = ssp || s_r.cfg.clock_phase;
        cpol_e = !ssp && s_r.cfg.clock_polarity;
        fs = (s_r.cfg.frame_size < `SM_FS_MIN) ? `SM_FS_MIN
            : s_r.cfg.frame_size;
        div_e = (s_r.cfg.divider_value < 16'(`SM_MIN_DIV))
            ? 16'(`SM_MIN_DIV) : s_r.cfg.divider_value;
        tick = s_r.cnt >= {1'b0, div_e[15:1]} - 16'h0001;
        dly_e = (s_r.dly_set > `SM_DLY_MAX) ? 5'h00
            : s_r.dly_set[4:0];
        rx_mask = 16'hFFFF >> (`SM_FS_MAX - fs);
        rx_in_data = {s_r.rx_sh[14:0], SERIAL_DATA_IN_I} & rx_mask;
        more = (s_r.cfg.transfer_mode == `SM_TM_RX)
            ? (s_r.rx_left != 16'h0000) : tx_out_valid;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        s_nxt.rx_dv = 1'b0;

        // Configuration is only taken while disabled; the interrupt mask at any time
        if (!CONTROLLER_ENABLE_I)
            s_nxt.cfg = CFG_I;
        if (RX_CAPTURE_DELAY_WE_I && !CONTROLLER_ENABLE_I)
            s_nxt.dly_set = RX_CAPTURE_DELAY_I;
        if (IRQ_MASK_WE_I)
            s_nxt.mask = IRQ_MASK_I;

        // Delayed capture; the delay must stay below half a bit
        if (s_r.pend)
        begin
            if (s_r.dly == 5'h00)
            begin
                s_nxt.pend = 1'b0;
                s_nxt.rx_sh = {s_r.rx_sh[14:0], SERIAL_DATA_IN_I};
                if (s_r.rxb == fs)
                begin
                    s_nxt.rxb = 4'h0;
                    rx_push = s_r.cfg.transfer_mode != `SM_TM_TX;
                end
                else
                    s_nxt.rxb = s_r.rxb + 4'h1;
            end
            else
                s_nxt.dly = s_r.dly - 5'h01;
        end

        s_nxt.cnt = (s_r.st == sm_pkg::SM_IDLE || tick) ? 16'h0000
            : s_r.cnt + 16'h0001;

        unique case (s_r.st)
            sm_pkg::SM_IDLE:
            begin
                s_nxt.sclk = cpol_e;
                s_nxt.cs_n = `SM_CS_IDLE;
                if (go && tx_out_valid)
                begin
                    tx_pop = 1'b1;
                    s_nxt.tx_sh = tx_out_data;
                    s_nxt.mosi = tx_out_data[fs];
                    s_nxt.bi = fs;
                    s_nxt.ph = 1'b0;
                    s_nxt.rxb = 4'h0;
                    s_nxt.pend = 1'b0;
                    s_nxt.rx_left = s_r.cfg.rx_frame_count - 16'h0001;
                    s_nxt.cs_n = ~s_r.cfg.slave_select;
                    s_nxt.st = ssp ? sm_pkg::SM_PULSE : sm_pkg::SM_BIT;
                    if (s_r.cfg.transfer_mode == `SM_TM_RX
                        && s_r.cfg.rx_frame_count == 16'h0000)
                        s_nxt.st = sm_pkg::SM_END;
                end
            end
            sm_pkg::SM_PULSE:
            begin
                // One serial clock period of frame pulse before each frame
                if (tick)
                begin
                    s_nxt.sclk = !s_r.sclk;
                    s_nxt.ph = !s_r.ph;
                    if (s_r.ph)
                    begin
                        s_nxt.cs_n = `SM_CS_IDLE;
                        s_nxt.st = sm_pkg::SM_BIT;
                    end
                end
            end
            sm_pkg::SM_BIT:
            begin
                if (tick)
                begin
                    s_nxt.sclk = !s_r.sclk;
                    s_nxt.ph = !s_r.ph;
                    if (!s_r.ph)
                    begin
                        if (cpha_e)
                            s_nxt.mosi = s_r.tx_sh[s_r.bi];
                        else
                        begin
                            s_nxt.pend = 1'b1;
                            s_nxt.dly = dly_e;
                        end
                    end
                    else
                    begin
                        if (cpha_e)
                        begin
                            s_nxt.pend = 1'b1;
                            s_nxt.dly = dly_e;
                        end
                        if (s_r.bi != 4'h0)
                        begin
                            s_nxt.bi = s_r.bi - 4'h1;
                            if (!cpha_e)
                                s_nxt.mosi = s_r.tx_sh[s_r.bi - 4'h1];
                        end
                        else if (more)
                        begin
                            // Next frame follows back to back in SPI, after a frame pulse in SSP
                            s_nxt.bi = fs;
                            if (s_r.cfg.transfer_mode == `SM_TM_RX)
                                s_nxt.rx_left = s_r.rx_left - 16'h0001;
                            else
                            begin
                                tx_pop = 1'b1;
                                s_nxt.tx_sh = tx_out_data;
                                if (!cpha_e)
                                    s_nxt.mosi = tx_out_data[fs];
                            end
                            if (ssp)
                            begin
                                s_nxt.st = sm_pkg::SM_PULSE;
                                s_nxt.cs_n = ~s_r.cfg.slave_select;
                            end
                        end
                        else
                            s_nxt.st = sm_pkg::SM_END;
                    end
                end
            end
            sm_pkg::SM_END:
            begin
                // Half a bit of hold lets the last delayed capture land
                if (tick)
                begin
                    s_nxt.st = sm_pkg::SM_IDLE;
                    s_nxt.cs_n = `SM_CS_IDLE;
                    s_nxt.sclk = cpol_e;
                end
            end
        endcase

        if (!go)
        begin
            s_nxt.st = sm_pkg::SM_IDLE;
            s_nxt.cs_n = `SM_CS_IDLE;
            s_nxt.sclk = cpol_e;
            s_nxt.pend = 1'b0;
        end
        s_nxt.oe_n = IF_OWNER_I != `SM_OWNER_MASTER;

        // Data port and status flags
        rx_pop = RX_RD_I && rx_out_valid;
        if (rx_pop)
        begin
            s_nxt.rx_data = rx_out_data;
            s_nxt.rx_dv = 1'b1;
        end
        txo_ev = TX_WR_I && !tx_in_ready && CONTROLLER_ENABLE_I;
        rxu_ev = RX_RD_I && !rx_out_valid;
        rxo_ev = rx_push && !rx_in_ready;
        // A new event wins over a clear in the same cycle
        s_nxt.tx_overflow_irq = txo_ev || (s_r.tx_overflow_irq && !TX_OVERFLOW_CLEAR_I);
        s_nxt.rx_overflow_irq = rxo_ev || (s_r.rx_overflow_irq && !RX_OVERFLOW_CLEAR_I);
        s_nxt.rx_underflow_irq = rxu_ev || (s_r.rx_underflow_irq && !RX_UNDERFLOW_CLEAR_I);
        raw = '0;
        raw[`SM_IRQ_TXE] = tx_level < TX_THRESHOLD_I;
        raw[`SM_IRQ_RXF] = rx_level > RX_THRESHOLD_I;
        raw[`SM_IRQ_TXO] = s_nxt.tx_overflow_irq;
        raw[`SM_IRQ_RXO] = s_nxt.rx_overflow_irq;
        raw[`SM_IRQ_RXU] = s_nxt.rx_underflow_irq;
        s_nxt.raw = raw;
        s_nxt.masked = raw & s_nxt.mask;
        s_nxt.irq = (|(raw & s_nxt.mask)) && CONTROLLER_ENABLE_I;
        s_nxt.stat.busy = s_nxt.st != sm_pkg::SM_IDLE;
        s_nxt.stat.tx_empty = tx_level == 4'h0;
        s_nxt.stat.tx_not_full = tx_in_ready;
        s_nxt.stat.rx_full = !rx_in_ready;
        s_nxt.stat.rx_not_empty = rx_out_valid;
        s_nxt.txl = tx_level;
        s_nxt.rxl = rx_level;
    end

    always_ff @(posedge CLK_I)
    begin
        if (!NRST_I)
        begin
            s_r <= '0;
            s_r.mask <= `SM_MASK_RST;
            s_r.cs_n <= `SM_CS_IDLE;
            s_r.oe_n <= 1'b1;
            s_r.stat.tx_empty <= 1'b1;
            s_r.stat.tx_not_full <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    assign SCLK_O = s_r.sclk;
    assign MOSI_O = s_r.mosi;
    assign CHIP_SELECT_N_O = s_r.cs_n;
    assign PIN_OE_N_O = s_r.oe_n;
    assign RX_DATA_O = s_r.rx_data;
    assign RX_DATA_VALID_O = s_r.rx_dv;
    assign STATUS_O = s_r.stat;
    assign TX_FILL_LEVEL_O = s_r.txl;
    assign RX_FILL_LEVEL_O = s_r.rxl;
    assign RAW_IRQ_STATUS_O = s_r.raw;
    assign MASKED_IRQ_STATUS_O = s_r.masked;
    assign IRQ_O = s_r.irq;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);

    a_cs_idle_high: assert property (
        s_r.st == sm_pkg::SM_IDLE |-> CHIP_SELECT_N_O == `SM_CS_IDLE)
        else $error("select active while idle");
    a_spi_cs_hold: assert property (
        (!ssp && s_r.st == sm_pkg::SM_BIT)
        |-> CHIP_SELECT_N_O == ~s_r.cfg.slave_select)
        else $error("select dropped inside SPI transfer");
    a_pins_released: assert property (
        IF_OWNER_I != `SM_OWNER_MASTER |=> PIN_OE_N_O)
        else $error("pins driven without ownership");
    a_sclk_min_half: assert property (
        disable iff (!NRST_I || !go)
        $changed(SCLK_O) |=> $stable(SCLK_O) [*3])
        else $error("serial clock too fast");
    a_txonly_discard: assert property (
        s_r.cfg.transfer_mode == `SM_TM_TX |-> !rx_push)
        else $error("receive data kept in transmit-only mode");
    a_delay_locked: assert property (
        CONTROLLER_ENABLE_I |=> $stable(s_r.dly_set))
        else $error("capture delay changed while enabled");
    a_cfg_locked: assert property (
        CONTROLLER_ENABLE_I |=> $stable(s_r.cfg))
        else $error("configuration changed while enabled");
    a_txe_level: assert property (
        tx_level < TX_THRESHOLD_I |=> RAW_IRQ_STATUS_O[`SM_IRQ_TXE])
        else $error("transmit level interrupt missing");
    a_rxf_level: assert property (
        rx_level <= RX_THRESHOLD_I |=> !RAW_IRQ_STATUS_O[`SM_IRQ_RXF])
        else $error("receive level interrupt without cause");
    a_underflow_latch: assert property (
        rxu_ev ##1 !RX_UNDERFLOW_CLEAR_I [*2]
        |-> RAW_IRQ_STATUS_O[`SM_IRQ_RXU])
        else $error("underflow not latched");
    a_irq_gate: assert property (
        !CONTROLLER_ENABLE_I |=> !IRQ_O)
        else $error("interrupt while disabled");

    c_spi_transfer: cover property (
        s_r.st == sm_pkg::SM_IDLE ##1 s_r.st == sm_pkg::SM_BIT);
    c_rx_only_done: cover property (
        s_r.cfg.transfer_mode == `SM_TM_RX && s_r.st == sm_pkg::SM_END);
    c_ssp_pulse: cover property (s_r.st == sm_pkg::SM_PULSE);
    c_tx_overflow: cover property (txo_ev);
endmodule // sm_serial_master

// >>> test/sm_serial_master_tb.sv
// Self-checking bench of the serial master with a behavioural slave.
// Assumes the slave model is compiled before this file.
`timescale 1ns/1ps
module sm_serial_master_tb;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic en = 1'h0;
    logic we = 1'h0;
    logic rd = 1'h0;
    logic mwe = 1'h0;
    logic dwe = 1'h0;
    logic [2:0] clr = 3'h0;
    logic [4:0] mask = 5'h1F;
    logic [1:0] owner = 2'h0;
    logic [3:0] txt = 4'h0;
    // SSP is never selected, so phase and polarity stay legal
    sm_pkg::sm_cfg_t cfg = '0;
    logic [15:0] wd = 16'h0000;
    logic [31:0] seed = 32'h0000004F;
    logic sclk, mosi, oe_n, rxv, irq, miso;
    logic [4:0] cs_n, raw, msk;
    logic [15:0] rxd;
    logic [3:0] txl, rxl;
    sm_pkg::sm_status_t stat;
    int miscompares = 0;
    int comparisons = 0;
    always #2.5 clk = ~clk;
    sm_serial_master u_dut (.CLK_I(clk), .NRST_I(nrst),
        .CONTROLLER_ENABLE_I(en), .IF_OWNER_I(owner), .CFG_I(cfg),
        // Zero-delay slave, so the delay stays below half a bit
        .RX_CAPTURE_DELAY_I(8'h02), .RX_CAPTURE_DELAY_WE_I(dwe),
        .TX_THRESHOLD_I(txt), .RX_THRESHOLD_I(4'h2), .IRQ_MASK_I(mask),
        .IRQ_MASK_WE_I(mwe), .TX_WR_I(we), .TX_DATA_I(wd), .RX_RD_I(rd),
        .TX_OVERFLOW_CLEAR_I(clr[0]), .RX_OVERFLOW_CLEAR_I(clr[1]),
        .RX_UNDERFLOW_CLEAR_I(clr[2]), .SERIAL_DATA_IN_I(miso),
        .SCLK_O(sclk), .MOSI_O(mosi), .CHIP_SELECT_N_O(cs_n),
        .PIN_OE_N_O(oe_n), .RX_DATA_O(rxd), .RX_DATA_VALID_O(rxv),
        .STATUS_O(stat), .TX_FILL_LEVEL_O(txl), .RX_FILL_LEVEL_O(rxl),
        .RAW_IRQ_STATUS_O(raw), .MASKED_IRQ_STATUS_O(msk), .IRQ_O(irq));
    sm_slave_model u_slave (.sclk_i(sclk), .mosi_i(mosi), .cs_n_i(cs_n[1]),
        .miso_o(miso));
    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Settings only land while disabled, so drop enable around them
    task automatic setup(input logic [1:0] m, input logic [15:0] n);
        en <= 1'h0;
        tick(1);
        cfg.transfer_mode <= m;
        cfg.rx_frame_count <= n;
        tick(1);
        en <= 1'h1;
        tick(1);
    endtask
    task automatic burst(input int n, ref logic [15:0] q[$]);
        logic [15:0] v;
        for (int i = 0; i < n; i++)
        begin
            v = 16'(xs());
            we <= 1'h1;
            wd <= v;
            q.push_back(v);
            tick(1);
        end
        we <= 1'h0;
    endtask
    // Busy rises late after writes, so also wait for an empty FIFO
    task automatic idle();
        tick(6);
        for (int i = 0; i < 4000; i++)
            if (stat.tx_empty !== 1'h1 || stat.busy !== 1'h0)
                tick(1);
    endtask
    task automatic pulse(input int b);
        clr[b] <= 1'h1;
        tick(1);
        clr[b] <= 1'h0;
        tick(2);
    endtask
    task automatic rdx(input logic [7:0] e);
        rd <= 1'h1;
        tick(1);
        rd <= 1'h0;
        #1;
        chk(rxv, 16'h0001);
        chk(rxd, {8'h00, e});
        tick(1);
    endtask
    initial
    begin
        #100000;
        miscompares++;
        tally_and_finish();
    end
    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------
    initial
    begin
        logic [15:0] q[$];
        int k;
        cfg.frame_size = 4'h7;
        cfg.slave_select = 5'h02;
        cfg.divider_value = 16'h0008;
        tick(6);
        nrst <= 1'h1;
        dwe <= 1'h1;
        tick(1);
        dwe <= 1'h0;
        #1;
        chk(cs_n, 16'h001F);
        chk(stat, 16'h000C);
        en <= 1'h1;
        burst(9, q);
        tick(3);
        #1;
        chk(txl, 16'h0008);
        chk(raw, 16'h0002);
        chk(stat.tx_not_full, 16'h0000);
        chk(oe_n, 16'h0001);
        chk(irq, 16'h0001);
        pulse(0);
        rd <= 1'h1;
        tick(1);
        rd <= 1'h0;
        mask <= 5'h1B;
        mwe <= 1'h1;
        tick(1);
        mwe <= 1'h0;
        tick(2);
        #1;
        chk(raw, 16'h0004);
        chk(msk, 16'h0000);
        chk(irq, 16'h0000);
        pulse(2);
        #1;
        chk(raw, 16'h0000);
        owner <= 2'h2;
        q.delete();
        setup(2'h0, 16'h0000);
        burst(4, q);
        tick(12);
        #1;
        chk(cs_n, 16'h001D);
        chk(oe_n, 16'h0000);
        idle();
        #1;
        chk(u_slave.nt, 16'h0001);
        for (k = 0; k < 4; k++)
            chk(u_slave.got[k], {8'h00, q[k][7:0]});
        chk(raw[4], 16'h0001);
        for (k = 0; k < 4; k++)
            rdx(8'hA5 ^ k[7:0]);
        // Mode 3 from here on: the slave's edges fit it as well
        cfg.clock_polarity <= 1'h1;
        cfg.clock_phase <= 1'h1;
        setup(2'h1, 16'h0000);
        burst(2, q);
        idle();
        #1;
        chk(rxl, 16'h0000);
        for (k = 4; k < 6; k++)
            chk(u_slave.got[k], {8'h00, q[k][7:0]});
        txt <= 4'h2;
        tick(2);
        #1;
        chk(raw[0], 16'h0001);
        chk(msk[0], 16'h0001);
        setup(2'h2, 16'h0003);
        burst(1, q);
        idle();
        tick(4);
        #1;
        chk(rxl, 16'h0003);
        for (k = 6; k < 9; k++)
            rdx(8'hA5 ^ k[7:0]);
        tally_and_finish();
    end
endmodule // sm_serial_master_tb

// >>> test/sm_slave_model.sv
// Behavioural serial slave, SPI mode 0 or 3, eight-bit frames.
// Assumes the master drives clock, data and an active-low select.
`timescale 1ns/1ps
module sm_slave_model (
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic cs_n_i,
    output logic miso_o
);
    logic [7:0] sh;
    logic [7:0] out;
    logic [7:0] got[$];
    int nb = 0;
    int nf = 0;
    int nt = 0;
    initial miso_o = 1'h0;
    // -------------------------------------------------------------------
    // Reply stream
    // -------------------------------------------------------------------
    always @(negedge cs_n_i)
    begin
        nb = 0;
        nt++;
        out = 8'hA5 ^ nf[7:0];
        miso_o = out[7];
    end
    always @(posedge sclk_i)
    if (!cs_n_i)
    begin
        sh = {sh[6:0], mosi_i};
        nb++;
        if (nb == 8)
        begin
            got.push_back(sh);
            nb = 0;
            nf++;
            out = 8'hA5 ^ nf[7:0];
        end
    end
    always @(negedge sclk_i)
    if (!cs_n_i)
        miso_o = out[7 - nb];
    // Released line must not keep its last level
    always @(posedge cs_n_i)
        miso_o = ~miso_o;
endmodule // sm_slave_model
